// [inc/seec_pkg.sv]
// Constants, types and register map of the serial memory command block
package seec_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 50;
  localparam int TMO_MS = 30;
  localparam int TMO_CYC = (CLK_HZ / 1000) * TMO_MS;
  localparam int SK_HALF_NS = 1000;
  localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int READY_SETTLE = 4;
  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_ISTAT = 8'h08;
  localparam logic [7:0] OFS_IMASK = 8'h0C;
  localparam int BUSY_POS = 31;
  localparam int CMD_POS = 28;
  localparam int EW_EN_POS = 10;
  localparam int TMO_POS = 9;
  localparam int LOADED_POS = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TMO = 1;
  localparam int IRQ_LOAD = 2;
  localparam int IRQ_W = 3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic RST_BUSY = 1'b1;
  localparam logic [2:0] RST_MASK = 3'h0;
  // ----------------------------------------------------------------
  // Commands and serial frame
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_READ = 3'h0, CMD_EW_DISABLE = 3'h1, CMD_EW_ENABLE = 3'h2, CMD_WRITE = 3'h3,
    CMD_WRITE_ALL = 3'h4, CMD_ERASE = 3'h5, CMD_ERASE_ALL = 3'h6, CMD_RELOAD = 3'h7
  } seec_cmd_t;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [7:0] EXT_EW_ENABLE = 8'hC0;
  localparam logic [7:0] EXT_EW_DISABLE = 8'h00;
  localparam logic [7:0] EXT_WRITE_ALL = 8'h40;
  localparam logic [7:0] EXT_ERASE_ALL = 8'h80;
  localparam int FRAME_W = 19;
  localparam logic [4:0] SHORT_BITS = 5'd11;
  localparam logic [4:0] LONG_BITS = 5'd19;
  localparam logic [2:0] MAC_LAST = 3'd6;
endpackage

// [src/seec_shift.sv]
// Serial frame engine toward the external memory with ready polling
`timescale 1ns/1ns
module seec_shift import seec_pkg::*; #(
  parameter int TMO_CYCLES = TMO_CYC,
  parameter int TMO_W = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request and answer
  input wire logic start_i,
  input wire logic [FRAME_W-1:0] frame_i,
  input wire logic [4:0] nbits_i,
  input wire logic rd_i,
  input wire logic wait_i,
  output logic done_o,
  output logic tmo_o,
  output logic [7:0] rx_o,
  // Memory pins
  output logic cs_o,
  output logic sk_o,
  output logic dio_o,
  output logic dio_oe_o,
  input wire logic dio_i
);
  typedef enum logic [1:0] {
    E_IDLE = 2'b00, E_SHIFT = 2'b01, E_GAP = 2'b11, E_WAIT = 2'b10
  } seec_est_t;
  typedef struct packed {
    seec_est_t st;
    logic [7:0] div;
    logic [4:0] bitn;
    logic [4:0] nb;
    logic rd;
    logic wt;
    logic [FRAME_W-1:0] sh;
    logic [7:0] rx;
    logic [TMO_W-1:0] tcnt;
    logic cs, sk, dout, oe, done, tmo;
    logic s1, s2, s3, lvl;
  } seec_eng_t;
  localparam logic [7:0] HALF = 8'(SK_HALF_CYC - 1);
  localparam logic [7:0] FULL = 8'(2 * SK_HALF_CYC - 1);
  // The level filter lags the pin by four cycles; without this margin a
  // level left over from the gap could end the ready poll too early
  localparam int SYNC_LAT = 4;
  localparam logic [TMO_W-1:0] POLL_MIN = TMO_W'(READY_SETTLE + SYNC_LAT);
  seec_eng_t r, n;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.tmo = 1'b0;
    // Pin passes three flops; a change counts once s2 and s3 agree
    n.s1 = dio_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.lvl = r.s3;
    end
    case (r.st)
      E_IDLE: begin
        if (start_i) begin
          n.sh = frame_i;
          n.nb = nbits_i;
          n.rd = rd_i;
          n.wt = wait_i;
          n.bitn = 5'd0;
          n.div = 8'd0;
          n.cs = 1'b1;
          n.st = E_SHIFT;
        end
      end
      E_SHIFT: begin
        n.div = r.div + 8'd1;
        n.dout = r.sh[FRAME_W-1];
        // Release the line while the memory answers a read
        n.oe = !(r.rd && r.bitn >= SHORT_BITS);
        if (r.div == HALF) begin
          n.sk = 1'b1;
          if (r.rd && r.bitn >= SHORT_BITS) begin
            n.rx = {r.rx[6:0], r.lvl};
          end
        end
        if (r.div == FULL) begin
          n.sk = 1'b0;
          n.div = 8'd0;
          n.sh = {r.sh[FRAME_W-2:0], 1'b0};
          n.bitn = r.bitn + 5'd1;
          if (r.bitn == r.nb - 5'd1) begin
            n.cs = 1'b0;
            n.oe = 1'b0;
            n.st = E_GAP;
          end
        end
      end
      E_GAP: begin
        // One bit time deselected before the ready poll
        n.div = r.div + 8'd1;
        if (r.div == FULL) begin
          n.div = 8'd0;
          if (r.wt) begin
            n.cs = 1'b1;
            n.tcnt = '0;
            n.st = E_WAIT;
          end else begin
            n.done = 1'b1;
            n.st = E_IDLE;
          end
        end
      end
      E_WAIT: begin
        n.tcnt = r.tcnt + 1'b1;
        // A line held high by a pull-up ends the wait once tcnt reaches POLL_MIN
        if (r.lvl && r.tcnt >= POLL_MIN) begin
          n.cs = 1'b0;
          n.done = 1'b1;
          n.st = E_IDLE;
        end else if (r.tcnt == TMO_W'(TMO_CYCLES - 1)) begin
          n.cs = 1'b0;
          n.tmo = 1'b1;
          n.st = E_IDLE;
        end
      end
      default: n.st = E_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign done_o = r.done;
  assign tmo_o = r.tmo;
  assign rx_o = r.rx;
  assign cs_o = r.cs;
  assign sk_o = r.sk;
  assign dio_o = r.dout;
  assign dio_oe_o = r.oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_wait_bounded: assert property (
    r.st == E_WAIT |-> r.tcnt < TMO_W'(TMO_CYCLES))
    else $error("ready wait ran past its limit");
  a_ready_ends: assert property (
    r.st == E_WAIT && r.lvl && r.tcnt >= POLL_MIN |=> done_o && !cs_o)
    else $error("high line did not end the wait");
endmodule // seec_shift

// [src/seec_ctrl.sv]
// Command and status register block of the serial memory controller
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
module seec_ctrl import seec_pkg::*; #(
  parameter int TMO_CYCLES = TMO_CYC,
  parameter logic [7:0] SIG_VALUE = 8'hA5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq_o,
  // Station address from the memory
  output logic [47:0] mac_addr_o,
  // Memory pins
  output logic mem_cs_o,
  output logic mem_clk_o,
  output logic memory_serial_data_line_o,
  output logic memory_serial_data_line_oe_o,
  input wire logic memory_serial_data_line_i
);
  typedef enum logic {
    T_IDLE = 1'b0,
    T_RUN = 1'b1
  } seec_tst_t;

  typedef struct packed {
    seec_tst_t st;
    logic busy;
    seec_cmd_t cmd;
    logic ew_en;
    logic tmo;
    logic loaded;
    logic [7:0] addr;
    logic [7:0] data;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic [2:0] idx;
    logic sig_ok;
    logic [47:0] mac;
    logic start;
    logic [FRAME_W-1:0] frame;
    logic [4:0] nbits;
    logic rd;
    logic wt;
  } seec_ctl_t;

  seec_ctl_t r, n;
  logic eng_done;
  logic eng_tmo;
  logic [7:0] eng_rx;
  logic req;
  logic [7:0] ofs;
  logic [31:0] cmd_word;

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  seec_shift #(
    .TMO_CYCLES(TMO_CYCLES),
    .TMO_W(20)
  ) u_shift (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(r.start),
    .frame_i(r.frame),
    .nbits_i(r.nbits),
    .rd_i(r.rd),
    .wait_i(r.wt),
    .done_o(eng_done),
    .tmo_o(eng_tmo),
    .rx_o(eng_rx),
    .cs_o(mem_cs_o),
    .sk_o(mem_clk_o),
    .dio_o(memory_serial_data_line_o),
    .dio_oe_o(memory_serial_data_line_oe_o),
    .dio_i(memory_serial_data_line_i)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Low address bits ignored; every register is one word
  assign req = wb_cyc_i && wb_stb_i && !r.ack;
  assign ofs = {wb_adr_i[7:2], 2'b00};
  assign cmd_word = {r.busy, r.cmd, 17'h0_0000, r.ew_en, r.tmo,
                     r.loaded, r.addr};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.start = 1'b0;
    // Ack lasts one cycle; the master drops the strobe after it
    n.ack = req;

    // Register reads, unmapped offsets answer zero
    if (req && !wb_we_i) begin
      case (ofs)
        OFS_CMD: n.rdat = cmd_word;
        OFS_DATA: n.rdat = {24'h00_0000, r.data};
        OFS_ISTAT: n.rdat = {29'h0000_0000, r.istat};
        OFS_IMASK: n.rdat = {29'h0000_0000, r.imask};
        default: n.rdat = 32'h0000_0000;
      endcase
    end

    // Register writes; clears come first so hardware sets win
    if (req && wb_we_i) begin
      case (ofs)
        OFS_CMD: begin
          if (wb_sel_i[1] && wb_dat_i[TMO_POS]) begin
            n.tmo = 1'b0;
          end
          if (wb_sel_i[1] && wb_dat_i[LOADED_POS]) begin
            n.loaded = 1'b0;
          end
          // Command fields are locked while a command runs
          if (!r.busy) begin
            if (wb_sel_i[0]) begin
              n.addr = wb_dat_i[7:0];
            end
            if (wb_sel_i[3] && wb_dat_i[BUSY_POS]) begin
              n.cmd = seec_cmd_t'(wb_dat_i[CMD_POS+2:CMD_POS]);
              n.busy = 1'b1;
            end
          end
        end
        OFS_DATA: begin
          if (wb_sel_i[0] && !r.busy) begin
            n.data = wb_dat_i[7:0];
          end
        end
        OFS_ISTAT: begin
          if (wb_sel_i[0]) begin
            n.istat = r.istat & ~wb_dat_i[IRQ_W-1:0];
          end
        end
        OFS_IMASK: begin
          if (wb_sel_i[0]) begin
            n.imask = wb_dat_i[IRQ_W-1:0];
          end
        end
        default: ;
      endcase
    end

    // Command sequencer
    case (r.st)
      T_IDLE: begin
        if (r.busy) begin
          n.start = 1'b1;
          n.st = T_RUN;
          n.rd = 1'b0;
          n.wt = 1'b0;
          n.nbits = SHORT_BITS;
          n.frame = {1'b1, OP_EXT, 8'h00, r.data};
          case (r.cmd)
            CMD_READ: begin
              n.frame = {1'b1, OP_READ, r.addr, 8'h00};
              n.nbits = LONG_BITS;
              n.rd = 1'b1;
            end
            CMD_EW_DISABLE: n.frame = {1'b1, OP_EXT, EXT_EW_DISABLE, 8'h00};
            CMD_EW_ENABLE: n.frame = {1'b1, OP_EXT, EXT_EW_ENABLE, 8'h00};
            CMD_WRITE: begin
              n.frame = {1'b1, OP_WRITE, r.addr, r.data};
              n.nbits = LONG_BITS;
              n.wt = 1'b1;
            end
            CMD_WRITE_ALL: begin
              n.frame = {1'b1, OP_EXT, EXT_WRITE_ALL, r.data};
              n.nbits = LONG_BITS;
              n.wt = 1'b1;
            end
            CMD_ERASE: begin
              n.frame = {1'b1, OP_ERASE, r.addr, 8'h00};
              n.wt = 1'b1;
            end
            CMD_ERASE_ALL: begin
              n.frame = {1'b1, OP_EXT, EXT_ERASE_ALL, 8'h00};
              n.wt = 1'b1;
            end
            CMD_RELOAD: begin
              // Reload walks bytes 0..6 as plain reads, or only byte 0 when the signature is bad
              n.frame = {1'b1, OP_READ, 5'h00, r.idx, 8'h00};
              n.nbits = LONG_BITS;
              n.rd = 1'b1;
            end
            default: n.busy = 1'b0;
          endcase
        end
      end
      T_RUN: begin
        if (eng_tmo) begin
          // Abandon the command and flag it failed
          n.st = T_IDLE;
          n.busy = 1'b0;
          n.tmo = 1'b1;
          n.istat[IRQ_TMO] = 1'b1;
          n.idx = 3'd0;
        end else if (eng_done) begin
          n.st = T_IDLE;
          if (r.cmd == CMD_RELOAD) begin
            n.idx = r.idx + 3'd1;
            if (r.idx == 3'd0) begin
              // First byte must carry the signature
              n.sig_ok = (eng_rx == SIG_VALUE);
              if (eng_rx != SIG_VALUE) begin
                n.busy = 1'b0;
                n.idx = 3'd0;
                n.istat[IRQ_DONE] = 1'b1;
              end
            end else begin
              n.mac = {r.mac[39:0], eng_rx};
              if (r.idx == MAC_LAST) begin
                n.loaded = r.sig_ok;
                n.busy = 1'b0;
                n.idx = 3'd0;
                n.istat[IRQ_DONE] = 1'b1;
                n.istat[IRQ_LOAD] = r.sig_ok;
              end
            end
          end else begin
            n.busy = 1'b0;
            n.istat[IRQ_DONE] = 1'b1;
            if (r.cmd == CMD_READ) begin
              n.data = eng_rx;
            end
            // Shadow of the memory's own write protection
            if (r.cmd == CMD_EW_ENABLE) begin
              n.ew_en = 1'b1;
            end
            if (r.cmd == CMD_EW_DISABLE) begin
              n.ew_en = 1'b0;
            end
          end
        end
      end
      default: n.st = T_IDLE;
    endcase

    // Level interrupt from unmasked sticky bits
    n.irq = |(n.istat & n.imask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset leaves a reload pending so the address loads at power-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.busy <= RST_BUSY;
      r.cmd <= CMD_RELOAD;
      r.addr <= RST_ADDR;
      r.data <= RST_DATA;
      r.imask <= RST_MASK;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
  assign irq_o = r.irq;
  assign mac_addr_o = r.mac;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cmd_finish;
    r.st == T_RUN && eng_done && r.cmd != CMD_RELOAD;
  endsequence

  sequence s_tmo_seen;
    r.st == T_RUN && eng_tmo;
  endsequence

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_tmo_idle: assert property (
    s_tmo_seen |=> !r.busy && r.st == T_IDLE)
    else $error("timeout did not return to idle");
  a_tmo_flag: assert property (
    s_tmo_seen |=> r.tmo && r.istat[IRQ_TMO])
    else $error("timeout flag not set");
  a_tmo_cmds: assert property (
    s_tmo_seen |-> r.cmd inside {CMD_WRITE, CMD_WRITE_ALL, CMD_ERASE, CMD_ERASE_ALL})
    else $error("timeout on a command that cannot time out");
  a_busy_clear: assert property (
    s_cmd_finish |=> !r.busy ##1 !r.start)
    else $error("busy not cleared after the frame");
  a_loaded_valid: assert property (
    $rose(r.loaded) |-> $past(r.sig_ok) && $past(r.cmd) == CMD_RELOAD)
    else $error("loaded flag without a valid memory");
  a_addr_reset: assert property (
    $fell(rst_i) |-> r.addr == RST_ADDR)
    else $error("address field not zero after reset");
  a_ew_cause: assert property (
    $rose(r.ew_en) |-> $past(r.cmd) == CMD_EW_ENABLE && $past(eng_done))
    else $error("write enable shadow set without enable command");
  a_start_busy: assert property (
    r.start |-> r.busy ##1 r.st == T_RUN)
    else $error("frame started with busy low");
endmodule // seec_ctrl

// [testbench/seec_mem_model.sv]
// Behavioural model of the external serial memory on the far side
`timescale 1ns/1ns
module seec_mem_model import seec_pkg::*; #(
  parameter logic [7:0] SIG = 8'hA5
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic present_i,
  input wire logic [15:0] busy_cyc_i,
  // Memory pins
  input wire logic cs_i,
  input wire logic sk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic doe_o
);
  logic [7:0] mem [0:255];
  logic wr_en_reg, sk_q, cs_q, rd_on;
  logic [4:0] cnt;
  logic [18:0] sh;
  logic [15:0] busy_cnt;
  logic [1:0] op;
  logic [7:0] adr, dat;
  // Power-up contents: signature, station address, rest erased
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
    mem[0] = SIG;
    for (int i = 1; i < 7; i++) mem[i] = 8'h10 + i[7:0];
    wr_en_reg = 1'b0;
    {sk_q, cs_q, rd_on, cnt, busy_cnt, doe_o, dout_o} = '0;
  end
  // Serial clock edges seen in the system clock; a real part is no faster
  always @(posedge clk_i) begin
    sk_q <= sk_i;
    cs_q <= cs_i;
    if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
    if (present_i && cs_i && sk_i && !sk_q) begin
      sh <= {sh[17:0], din_i};
      cnt <= cnt + 1;
    end
    if (present_i && cs_i && !sk_i && sk_q) begin
      if (cnt == 11) begin
        rd_on = (sh[9:8] == OP_READ);
        adr = sh[7:0];
      end
      if (rd_on && cnt >= 11 && cnt < 19) begin
        dout_o <= mem[adr][18 - cnt];
        doe_o <= 1'b1;
      end
    end
    // Ready status while selected between frames
    if (present_i && cs_i && cs_q && cnt == 0) begin
      doe_o <= 1'b1;
      dout_o <= (busy_cnt == 0);
    end
    if (!cs_i) doe_o <= 1'b0;
    // Frame acts when select falls
    if (cs_q && !cs_i) begin
      // A select pulse with no frame, as in the ready poll, acts on nothing
      op = (cnt == 19) ? sh[17:16] : (cnt == 11) ? sh[9:8] : OP_READ;
      adr = (cnt == 19) ? sh[15:8] : sh[7:0];
      dat = (cnt == 19) ? sh[7:0] : 8'hFF;
      if (present_i && op == OP_EXT && adr == EXT_EW_ENABLE) wr_en_reg = 1'b1;
      else if (present_i && op == OP_EXT && adr == EXT_EW_DISABLE) wr_en_reg = 1'b0;
      else if (present_i && wr_en_reg && op != OP_READ) begin
        for (int i = 0; i < 256; i++)
          if (op == OP_EXT || i == adr) mem[i] = (op == OP_ERASE) ? 8'hFF : dat;
        busy_cnt <= busy_cyc_i;
      end
      cnt <= '0;
      rd_on = 1'b0;
    end
  end
endmodule // seec_mem_model

// [testbench/testbench.sv]
// Self-checking bench of the serial memory command block
`timescale 1ns/1ns
module testbench import seec_pkg::*;;
  localparam int TMO = 200;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack, irq, cs, sk, dout, doe, m_dout, m_doe, line;
  logic [47:0] mac;
  logic present = 1'b1;
  logic [1:0] pull = 2'b00;
  logic [15:0] busy_cyc = 16'h0032;
  logic tog = 1'b0;
  logic [7:0] lfsr_reg = 8'h31;
  logic [31:0] exp_m[$], exp_v[$];
  int num_errors = 0, total_checks = 0, cyc_cnt = 0, n;
  logic [7:0] a, d;
  seec_cmd_t tbl [8] = '{CMD_WRITE, CMD_WRITE_ALL, CMD_ERASE, CMD_ERASE_ALL,
                         CMD_READ, CMD_EW_ENABLE, CMD_EW_DISABLE, CMD_RELOAD};
  // --------------------------------------------------------------
  // Clock, wire level and instances
  // --------------------------------------------------------------
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tog <= ~tog;
    cyc_cnt <= cyc_cnt + 1;
  end
  // Undriven and unpulled line changes every cycle so no stale value survives
  assign line = doe ? dout : m_doe ? m_dout : pull[1] ? pull[0] : tog;
  seec_ctrl #(.TMO_CYCLES(TMO)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq),
    .mac_addr_o(mac), .mem_cs_o(cs), .mem_clk_o(sk), .memory_serial_data_line_o(dout),
    .memory_serial_data_line_oe_o(doe), .memory_serial_data_line_i(line));
  seec_mem_model mdl (.clk_i(clk_i), .present_i(present), .busy_cyc_i(busy_cyc),
    .cs_i(cs), .sk_i(sk), .din_i(line), .dout_o(m_dout), .doe_o(m_doe));
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [7:0] rnd();
    lfsr_reg = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    return lfsr_reg;
  endfunction
  // Classic cycle; a read notes its expectation, mask zero means unchecked
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] dt,
                    input logic [31:0] m, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= ad;
    wb_wdat <= dt;
    if (!we) begin
      exp_m.push_back(m);
      exp_v.push_back(dt & m);
    end
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    logic [31:0] r;
    wb(1'b1, ad, dt, 32'h0000_0000, r);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    wb(1'b0, ad, e, m, r);
  endtask
  task automatic idle(output int c);
    logic [31:0] r;
    int t0;
    t0 = cyc_cnt;
    do wb(1'b0, OFS_CMD, 32'h0000_0000, 32'h0000_0000, r); while (r[BUSY_POS] !== 1'b0);
    c = cyc_cnt - t0;
  endtask
  task automatic run(input seec_cmd_t c, input logic [7:0] ad);
    wr(OFS_CMD, {1'b1, c, 20'h0_0000, ad});
    idle(n);
  endtask
  task automatic rd_mem(input logic [7:0] ad, input logic [7:0] e);
    run(CMD_READ, ad);
    rd(OFS_DATA, {24'h00_0000, e}, 32'h0000_00FF);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Read answers compared against the oldest noted expectation
  always @(posedge clk_i) begin : mon_blk
    logic [31:0] m, v;
    if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_m.size() > 0) begin
      m = exp_m.pop_front();
      v = exp_v.pop_front();
      if (m != 0) chk("read data", v, wb_rdat & m);
    end
  end
  // Watchdog well beyond the expected run of some thirty-five thousand cycles
  initial begin
    #5_000_000;
    num_errors++;
    end_of_test();
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CMD, 32'h8000_0000, 32'h8000_03FF);
    idle(n);
    rd(OFS_CMD, 32'h0000_0100, 32'h0000_0300);
    chk("station address", 48'h1112_1314_1516, mac);
    rd(OFS_ISTAT, 32'h0000_0004, 32'h0000_0004);
    wr(OFS_CMD, 32'h0000_0100);
    rd(OFS_CMD, 32'h0000_0000, 32'h0000_0300);
    a = rnd() | 8'h80;
    wr(OFS_DATA, {24'h00_0000, rnd()});
    run(CMD_WRITE, a);
    rd_mem(a, 8'hFF);
    run(CMD_EW_ENABLE, 8'h00);
    rd(OFS_CMD, 32'h0000_0400, 32'h0000_0400);
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 8'h07 : (i == 1) ? 8'hFF : rnd() | 8'h80;
      d = rnd();
      wr(OFS_DATA, {24'h00_0000, d});
      run(CMD_WRITE, a);
      rd_mem(a, d);
    end
    run(CMD_ERASE, a);
    rd(OFS_CMD, {24'h00_0000, a}, 32'h0000_00FF);
    rd_mem(a, 8'hFF);
    busy_cyc <= 16'h0096;
    d = rnd();
    wr(OFS_DATA, {24'h00_0000, d});
    run(CMD_WRITE_ALL, 8'h00);
    rd(OFS_CMD, 32'h0000_0000, 32'h0000_0200);
    rd_mem(rnd(), d);
    run(CMD_ERASE_ALL, 8'h00);
    rd_mem(rnd(), 8'hFF);
    wr(OFS_DATA, 32'h0000_00A5);
    run(CMD_WRITE, 8'h00);
    run(CMD_RELOAD, 8'h00);
    rd(OFS_CMD, 32'h0000_0100, 32'h0000_0300);
    chk("station address", 48'hFFFF_FFFF_FFFF, mac);
    run(CMD_EW_DISABLE, 8'h00);
    wr(OFS_DATA, {24'h00_0000, rnd()});
    run(CMD_WRITE, 8'h07);
    rd_mem(8'h07, 8'hFF);
    // Loaded is still set from the reload above; the loop expects it clear
    wr(OFS_CMD, 32'h0000_0100);
    // No memory, line pulled low: only write and erase kinds give up
    present <= 1'b0;
    pull <= 2'b10;
    wr(OFS_IMASK, 32'h0000_0002);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_ISTAT, 32'h0000_0007);
      run(tbl[i], 8'h20);
      if (i < 4) chk("wait window", 1'b1, n >= TMO + 11 * 40 && n < TMO + 1000);
      rd(OFS_CMD, (i < 4) ? 32'h0000_0200 : 32'h0000_0000, 32'h0000_0300);
      @(posedge clk_i);
      chk("irq", i < 4, irq);
      if (i == 0) begin
        wr(OFS_IMASK, 32'h0000_0000);
        @(posedge clk_i);
        chk("irq", 1'b0, irq);
        wr(OFS_IMASK, 32'h0000_0002);
        @(posedge clk_i);
        chk("irq", 1'b1, irq);
      end
      wr(OFS_CMD, 32'h0000_0200);
      rd(OFS_CMD, 32'h0000_0000, 32'h0000_0200);
    end
    // No memory, line pulled high: never gives up
    pull <= 2'b11;
    run(CMD_WRITE, 8'h30);
    chk("busy clear", 1'b1, n < 19 * 40 + TMO);
    run(CMD_ERASE_ALL, 8'h00);
    rd(OFS_CMD, 32'h0000_0000, 32'h0000_0200);
    rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
    end_of_test();
  end
endmodule // testbench
